// *** rtl/oag_regs.vh ***
// Constants for the operand address generator
`ifndef OAG_REGS_VH
`define OAG_REGS_VH

// ------------------------------------------------------------------
// Addressing mode encodings
// ------------------------------------------------------------------
`define OAG_SMODE_REG   2'b00
`define OAG_SMODE_IDX   2'b01
`define OAG_DMODE_REG   1'b0
`define OAG_DMODE_IDX   1'b1

// ------------------------------------------------------------------
// Special register numbers
// ------------------------------------------------------------------
`define OAG_REG_PC      4'h0
`define OAG_REG_SR      4'h2

// ------------------------------------------------------------------
// Address arithmetic and reset values
// ------------------------------------------------------------------
`define OAG_WORD_STEP   16'h0002
`define OAG_ZERO_WORD   16'h0000
`define OAG_PC_RESET    16'h0000
`define OAG_REG_RESET   16'h0000

`endif

// *** rtl/byte_result.v ***
// Byte or word shaping of an operand with its sign and zero flags
`timescale 1ns/1ps
`include "oag_regs.vh"

module byte_result (
    input  wire [15:0] word_i,     // Raw word from register or bus
    input  wire        byte_i,     // Byte-sized instruction
    input  wire        lane_i,     // Byte address bit 0, selects high lane
    output wire [15:0] result_o,   // Shaped result
    output wire        neg_o,      // Sign of the shaped result
    output wire        zero_o      // Shaped result is zero
);

    wire [7:0] lane_byte;

    assign lane_byte = lane_i ? word_i[15:8] : word_i[7:0];
    // High byte forced to zero for byte results
    assign result_o  = byte_i ? {8'h00, lane_byte} : word_i;
    // Flags follow the width actually operated on
    assign neg_o     = byte_i ? lane_byte[7] : word_i[15];
    assign zero_o    = (result_o == `OAG_ZERO_WORD);

endmodule

// *** rtl/operand_address_generation.v ***
// Operand fetch, effective address forming and move execution
`timescale 1ns/1ps
`include "oag_regs.vh"

module operand_address_generation (
    input  wire        clk_sys_i,     // System clock, 100 MHz
    input  wire        reset_i,       // Synchronous reset, active high
    input  wire        start_i,       // Begin one instruction, idle only
    input  wire [15:0] instr_addr_i,  // Address of the opcode word
    input  wire [3:0]  src_reg_i,     // Source general_register number
    input  wire [1:0]  src_mode_i,    // source_mode_field
    input  wire [3:0]  dst_reg_i,     // Destination general_register number
    input  wire        dst_mode_i,    // Destination mode bit
    input  wire        byte_i,        // Byte-sized instruction
    input  wire        reg_ld_i,      // Preload a register while idle
    input  wire [3:0]  reg_ld_sel_i,  // Register to preload
    input  wire [15:0] reg_ld_data_i, // Preload value
    input  wire [15:0] mem_rdata_i,   // Bus read data
    input  wire        mem_ack_i,     // Bus completes current access
    output reg  [15:0] mem_addr_o,    // Bus byte address
    output reg         mem_rd_o,      // Read request, held until ack
    output reg         mem_wr_o,      // Write request, held until ack
    output reg  [15:0] mem_wdata_o,   // Bus write data
    output reg         mem_byte_o,    // Access is byte wide
    output reg         busy_o,        // Instruction in progress
    output reg         done_o,        // One-cycle end of instruction
    output reg  [15:0] pc_o,          // Address of the next instruction
    output reg  [15:0] result_o,      // Moved operand value
    output reg         flag_n_o,      // Negative flag of the result
    output reg         flag_z_o,      // Zero flag of the result
    output reg  [15:0] rd_data_o,     // Register read-back, one cycle late
    input  wire [3:0]  rd_sel_i       // Register read-back select
);

    // --------------------------------------------------------------
    // States
    // --------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_SREG = 3'd1;
    localparam [2:0] S_SEXT = 3'd2;
    localparam [2:0] S_SRD  = 3'd3;
    localparam [2:0] S_DEXT = 3'd4;
    localparam [2:0] S_DWR  = 3'd5;
    localparam [2:0] S_FIN  = 3'd6;

    reg [2:0]  state_r;
    reg [15:0] pc_r;        // Address of the last word fetched
    reg [3:0]  src_reg_r;
    reg [1:0]  src_mode_r;
    reg [3:0]  dst_reg_r;
    reg        dst_mode_r;
    reg        byte_r;
    reg [15:0] src_ea_r;
    reg [15:0] dst_ea_r;
    reg [15:0] opnd_r;
    reg        neg_r;
    reg        zero_r;
    reg        jump_r;      // Destination was the PC itself
    reg [15:0] regs [0:15];
    integer    i;

    wire [15:0] ext_addr;
    wire [15:0] shp_in;
    wire        shp_lane;
    wire [15:0] shp_res;
    wire        shp_neg;
    wire        shp_zero;

    assign ext_addr = pc_r + `OAG_WORD_STEP;

    // --------------------------------------------------------------
    // Base register selection
    // --------------------------------------------------------------
    // PC reads as the extension word address; SR reads as zero
    function [15:0] index_base;
        input [3:0]  sel;
        input [15:0] ext_a;
        begin
            if (sel == `OAG_REG_PC)
                index_base = ext_a;
            else if (sel == `OAG_REG_SR)
                index_base = `OAG_ZERO_WORD;
            else
                index_base = regs[sel];
        end
    endfunction

    // Register mode value; PC shows the word after the opcode
    function [15:0] reg_value;
        input [3:0]  sel;
        input [15:0] ext_a;
        begin
            if (sel == `OAG_REG_PC)
                reg_value = ext_a;
            else
                reg_value = regs[sel];
        end
    endfunction

    // --------------------------------------------------------------
    // Operand shaping
    // --------------------------------------------------------------
    assign shp_in   = (state_r == S_SRD) ? mem_rdata_i
                                         : reg_value(src_reg_r, ext_addr);
    assign shp_lane = (state_r == S_SRD) ? src_ea_r[0] : 1'b0;

    byte_result u_shape (
        .word_i   (shp_in),
        .byte_i   (byte_r),
        .lane_i   (shp_lane),
        .result_o (shp_res),
        .neg_o    (shp_neg),
        .zero_o   (shp_zero)
    );

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    // Shared step once the source operand is known
    task to_dest;
        begin
            opnd_r <= shp_res;
            neg_r  <= shp_neg;
            zero_r <= shp_zero;
            if (dst_mode_r == `OAG_DMODE_IDX) begin
                state_r    <= S_DEXT;
                mem_rd_o   <= 1'b1;
                mem_byte_o <= 1'b0;
                mem_addr_o <= ext_addr;
            end else begin
                state_r <= S_FIN;
                if (dst_reg_r == `OAG_REG_PC)
                    jump_r <= 1'b1;
                else
                    regs[dst_reg_r] <= shp_res;
            end
        end
    endtask

    always @(posedge clk_sys_i) begin
        done_o    <= 1'b0;
        rd_data_o <= reg_value(rd_sel_i, ext_addr);
        if (reset_i) begin
            state_r     <= S_IDLE;
            pc_r        <= `OAG_PC_RESET;
            src_reg_r   <= 4'h0;
            src_mode_r  <= `OAG_SMODE_REG;
            dst_reg_r   <= 4'h0;
            dst_mode_r  <= `OAG_DMODE_REG;
            byte_r      <= 1'b0;
            src_ea_r    <= `OAG_ZERO_WORD;
            dst_ea_r    <= `OAG_ZERO_WORD;
            opnd_r      <= `OAG_ZERO_WORD;
            neg_r       <= 1'b0;
            zero_r      <= 1'b0;
            jump_r      <= 1'b0;
            mem_addr_o  <= `OAG_ZERO_WORD;
            mem_rd_o    <= 1'b0;
            mem_wr_o    <= 1'b0;
            mem_wdata_o <= `OAG_ZERO_WORD;
            mem_byte_o  <= 1'b0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            pc_o        <= `OAG_PC_RESET;
            result_o    <= `OAG_ZERO_WORD;
            flag_n_o    <= 1'b0;
            flag_z_o    <= 1'b0;
            rd_data_o   <= `OAG_ZERO_WORD;
            for (i = 0; i < 16; i = i + 1)
                regs[i] <= `OAG_REG_RESET;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (start_i) begin
                        busy_o     <= 1'b1;
                        pc_r       <= instr_addr_i;
                        src_reg_r  <= src_reg_i;
                        src_mode_r <= src_mode_i;
                        dst_reg_r  <= dst_reg_i;
                        dst_mode_r <= dst_mode_i;
                        byte_r     <= byte_i;
                        jump_r     <= 1'b0;
                        if (src_mode_i == `OAG_SMODE_IDX) begin
                            state_r    <= S_SEXT;
                            mem_rd_o   <= 1'b1;
                            mem_byte_o <= 1'b0;
                            mem_addr_o <= instr_addr_i + `OAG_WORD_STEP;
                        end else begin
                            // Other source modes treated as register
                            state_r <= S_SREG;
                        end
                    end else if (reg_ld_i &&
                                 reg_ld_sel_i != `OAG_REG_PC) begin
                        regs[reg_ld_sel_i] <= reg_ld_data_i;
                    end
                end
                S_SREG: begin
                    to_dest;
                end
                S_SEXT: begin
                    if (mem_ack_i) begin
                        mem_rd_o   <= 1'b0;
                        // Base register only read, never written
                        src_ea_r   <= index_base(src_reg_r, ext_addr)
                                      + mem_rdata_i;
                        mem_addr_o <= index_base(src_reg_r, ext_addr)
                                      + mem_rdata_i;
                        pc_r       <= ext_addr;
                        state_r    <= S_SRD;
                    end
                end
                S_SRD: begin
                    if (mem_rd_o == 1'b0) begin
                        mem_rd_o   <= 1'b1;
                        mem_byte_o <= byte_r;
                    end else if (mem_ack_i) begin
                        mem_rd_o <= 1'b0;
                        to_dest;
                    end
                end
                S_DEXT: begin
                    if (mem_ack_i) begin
                        mem_rd_o   <= 1'b0;
                        dst_ea_r   <= index_base(dst_reg_r, ext_addr)
                                      + mem_rdata_i;
                        mem_addr_o <= index_base(dst_reg_r, ext_addr)
                                      + mem_rdata_i;
                        mem_wdata_o <= byte_r ? {opnd_r[7:0], opnd_r[7:0]}
                                              : opnd_r;
                        mem_byte_o <= byte_r;
                        mem_wr_o   <= 1'b1;
                        pc_r       <= ext_addr;
                        state_r    <= S_DWR;
                    end
                end
                S_DWR: begin
                    if (mem_ack_i) begin
                        mem_wr_o <= 1'b0;
                        state_r  <= S_FIN;
                    end
                end
                S_FIN: begin
                    state_r  <= S_IDLE;
                    busy_o   <= 1'b0;
                    done_o   <= 1'b1;
                    pc_o     <= jump_r ? opnd_r : ext_addr;
                    result_o <= opnd_r;
                    flag_n_o <= neg_r;
                    flag_z_o <= zero_r;
                end
                default: begin
                    state_r  <= S_IDLE;
                    busy_o   <= 1'b0;
                    mem_rd_o <= 1'b0;
                    mem_wr_o <= 1'b0;
                end
            endcase
        end
    end

endmodule

// *** dv/oag_mem_model.sv ***
// Word memory on the far side of the operand bus
`timescale 1ns/1ps
module oag_mem_model (
    input  wire        clk_sys_i, // Clock
    input  wire [3:0]  wait_i,    // Wait cycles before ack
    input  wire [15:0] addr_i,    // Byte address
    input  wire        rd_i,      // Read request
    input  wire        wr_i,      // Write request
    input  wire        byte_i,    // Byte access
    input  wire [15:0] wdata_i,   // Write data
    output reg  [15:0] rdata_o,   // Read data
    output reg         ack_o      // Access complete
);
    reg [15:0] m [0:511];
    reg [3:0]  cnt_r;
    initial begin
        ack_o = 1'b0;
        rdata_o = 16'h0000;
        cnt_r = 4'h0;
    end
    always @(posedge clk_sys_i) begin
        if (ack_o || !(rd_i || wr_i)) begin
            ack_o <= 1'b0;
            cnt_r <= 4'h0;
            // Toggle so stale read data is never mistaken for valid
            rdata_o <= ~rdata_o;
        end else if (cnt_r < wait_i) begin
            cnt_r <= cnt_r + 4'h1;
        end else begin
            ack_o <= 1'b1;
            if (rd_i)
                rdata_o <= m[addr_i[9:1]];
            if (wr_i && !byte_i)
                m[addr_i[9:1]] <= wdata_i;
            if (wr_i && byte_i && addr_i[0])
                m[addr_i[9:1]][15:8] <= wdata_i[7:0];
            if (wr_i && byte_i && !addr_i[0])
                m[addr_i[9:1]][7:0] <= wdata_i[7:0];
        end
    end
endmodule

// *** dv/operand_address_generation_chk.sv ***
// Port-level assertions for the operand address generator
`timescale 1ns/1ps
module operand_address_generation_chk (
    input wire        clk_sys_i,    // Clock
    input wire        reset_i,      // Sync reset
    input wire        start_i,      // Start
    input wire [15:0] instr_addr_i, // Opcode address
    input wire [1:0]  src_mode_i,   // Source mode
    input wire        dst_mode_i,   // Destination mode
    input wire [3:0]  dst_reg_i,    // Destination register
    input wire        byte_i,       // Byte op
    input wire        mem_ack_i,    // Bus ack
    input wire        mem_rd_o,     // Bus read
    input wire        mem_wr_o,     // Bus write
    input wire [15:0] mem_addr_o,   // Bus address
    input wire        busy_o,       // Busy
    input wire        done_o,       // Done pulse
    input wire [15:0] pc_o,         // Next PC
    input wire [15:0] result_o,     // Result
    input wire        flag_n_o,     // Negative
    input wire        flag_z_o      // Zero
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    reg  byte_r;
    wire take = start_i && !busy_o;
    always @(posedge clk_sys_i) begin
        if (reset_i)
            byte_r <= 1'b0;
        else if (take)
            byte_r <= byte_i;
    end
    sequence reg_take;
        take && src_mode_i == 2'b00 && !dst_mode_i && dst_reg_i != 4'h0;
    endsequence
    sequence reg_finish;
        !done_o [*2] ##1 done_o;
    endsequence
    chk_take_busy: assert property (take |=> busy_o)
        else $error("busy not raised after start");
    chk_reg_latency: assert property (reg_take |=> reg_finish
        ##0 pc_o == $past(instr_addr_i, 3) + 16'h0002)
        else $error("register move timing or pc wrong");
    chk_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_done_idle: assert property (done_o |-> !busy_o)
        else $error("busy high with done");
    chk_ext_fetch: assert property (take && src_mode_i == 2'b01
        |=> mem_rd_o && mem_addr_o == $past(instr_addr_i) + 16'h0002)
        else $error("source extension fetch wrong");
    chk_req_hold: assert property ((mem_rd_o || mem_wr_o) && !mem_ack_i
        |=> $stable(mem_addr_o) && $stable({mem_rd_o, mem_wr_o}))
        else $error("bus request changed before ack");
    chk_byte_result: assert property (done_o && byte_r |->
        result_o[15:8] == 8'h00 && flag_n_o == result_o[7]
        && flag_z_o == (result_o[7:0] == 8'h00))
        else $error("byte result or flags wrong");
    chk_word_flags: assert property (done_o && !byte_r |->
        flag_n_o == result_o[15] && flag_z_o == (result_o == 16'h0000))
        else $error("word flags wrong");
endmodule
bind operand_address_generation operand_address_generation_chk chk (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .start_i(start_i),
    .instr_addr_i(instr_addr_i), .src_mode_i(src_mode_i),
    .dst_mode_i(dst_mode_i), .dst_reg_i(dst_reg_i), .byte_i(byte_i),
    .mem_ack_i(mem_ack_i), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .busy_o(busy_o), .done_o(done_o),
    .pc_o(pc_o), .result_o(result_o), .flag_n_o(flag_n_o),
    .flag_z_o(flag_z_o));

// *** dv/operand_address_generation_tb.sv ***
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("FAIL %0t got %h want %h", $time, a, b); end end
module operand_address_generation_tb;
    reg         clk_sys_i, reset_i, start_i, dst_mode_i, byte_i, reg_ld_i;
    reg  [15:0] instr_addr_i, reg_ld_data_i;
    reg  [3:0]  src_reg_i, dst_reg_i, reg_ld_sel_i, rd_sel_i, wait_r;
    reg  [1:0]  src_mode_i;
    wire [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, pc_o, result_o;
    wire [15:0] rd_data_o;
    wire        mem_ack_i, mem_rd_o, mem_wr_o, mem_byte_o, busy_o, done_o;
    wire        flag_n_o, flag_z_o;
    integer     fail_count = 0, n_tests = 0, cyc = 0;
    operand_address_generation dut (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .start_i(start_i), .instr_addr_i(instr_addr_i),
        .src_reg_i(src_reg_i), .src_mode_i(src_mode_i),
        .dst_reg_i(dst_reg_i), .dst_mode_i(dst_mode_i), .byte_i(byte_i),
        .reg_ld_i(reg_ld_i), .reg_ld_sel_i(reg_ld_sel_i),
        .reg_ld_data_i(reg_ld_data_i), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
        .mem_byte_o(mem_byte_o), .busy_o(busy_o), .done_o(done_o),
        .pc_o(pc_o), .result_o(result_o), .flag_n_o(flag_n_o),
        .flag_z_o(flag_z_o), .rd_data_o(rd_data_o), .rd_sel_i(rd_sel_i));
    oag_mem_model mem (.clk_sys_i(clk_sys_i), .wait_i(wait_r),
        .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
        .byte_i(mem_byte_o), .wdata_i(mem_wdata_o),
        .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task poke(input [15:0] a, input [15:0] d);
        mem.m[a[9:1]] = d;
    endtask
    task load(input [3:0] s, input [15:0] d);
        begin
            reg_ld_sel_i = s;
            reg_ld_data_i = d;
            reg_ld_i = 1'b1;
            @(posedge clk_sys_i); #1 reg_ld_i = 1'b0;
            // Idle edge so a following load never re-raises in one step
            @(posedge clk_sys_i); #1;
        end
    endtask
    task rdreg(input [3:0] s, input [15:0] e);
        begin
            rd_sel_i = s;
            @(posedge clk_sys_i); #1 `CHK(rd_data_o, e)
        end
    endtask
    task run(input [15:0] ia, input [1:0] sm, input [3:0] sr,
             input dm, input [3:0] dr, input b);
        integer n;
        begin
            instr_addr_i = ia;
            src_mode_i = sm;
            src_reg_i = sr;
            dst_mode_i = dm;
            dst_reg_i = dr;
            byte_i = b;
            start_i = 1'b1;
            @(posedge clk_sys_i); #1 start_i = 1'b0;
            n = 0;
            while (done_o !== 1'b1 && n < 200) begin
                @(posedge clk_sys_i); #1 n = n + 1;
            end
            `CHK(done_o, 1'b1)
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reg;
        begin
            load(4'ha, 16'ha023);
            load(4'hb, 16'hfa15);
            run(16'h0100, 2'b00, 4'ha, 1'b0, 4'hb, 1'b0);
            `CHK(result_o, 16'ha023)
            `CHK(pc_o, 16'h0102)
            rdreg(4'ha, 16'ha023);
            rdreg(4'hb, 16'ha023);
            // Move into the PC redirects the next instruction
            run(16'h0100, 2'b00, 4'hb, 1'b0, 4'h0, 1'b0);
            `CHK(pc_o, 16'ha023)
        end
    endtask
    task t_byte;
        begin
            load(4'h4, 16'h1280);
            run(16'h0100, 2'b00, 4'h4, 1'b0, 4'h7, 1'b1);
            `CHK(flag_n_o, 1'b1)
            rdreg(4'h7, 16'h0080);
            load(4'h4, 16'h8100);
            run(16'h0100, 2'b00, 4'h4, 1'b0, 4'h7, 1'b1);
            `CHK({flag_n_o, flag_z_o}, 2'b01)
        end
    endtask
    task t_bmem;
        begin
            wait_r = 4'h1;
            poke(16'h0302, 16'h0001);
            poke(16'h0304, 16'h0000);
            poke(16'h1100, 16'h8c3e);
            poke(16'h1104, 16'hffff);
            load(4'h9, 16'h1100);
            load(4'hc, 16'h1104);
            // High lane read, low lane write
            run(16'h0300, 2'b01, 4'h9, 1'b1, 4'hc, 1'b1);
            `CHK(result_o, 16'h008c)
            `CHK(flag_n_o, 1'b1)
            `CHK(mem.m[9'h082], 16'hff8c)
            `CHK(pc_o, 16'h0306)
        end
    endtask
    task t_idx;
        begin
            wait_r = 4'h2;
            poke(16'hff14, 16'h0002);
            poke(16'hff16, 16'h0006);
            poke(16'h1082, 16'h1234);
            poke(16'h1092, 16'h5555);
            load(4'h5, 16'h1080);
            load(4'h6, 16'h108c);
            run(16'hff12, 2'b01, 4'h5, 1'b1, 4'h6, 1'b0);
            `CHK(mem.m[9'h049], 16'h1234)
            `CHK(pc_o, 16'hff18)
            rdreg(4'h5, 16'h1080);
            rdreg(4'h6, 16'h108c);
        end
    endtask
    task t_sym;
        begin
            wait_r = 4'h0;
            poke(16'hff14, 16'hf102);
            poke(16'hff16, 16'h11fe);
            poke(16'hf016, 16'ha123);
            poke(16'h1114, 16'h5555);
            run(16'hff12, 2'b01, 4'h0, 1'b1, 4'h0, 1'b0);
            `CHK(mem.m[9'h08a], 16'ha123)
            `CHK(pc_o, 16'hff18)
        end
    endtask
    task t_abs;
        begin
            load(4'h2, 16'h0ff0);
            poke(16'h0202, 16'h1082);
            run(16'h0200, 2'b01, 4'h2, 1'b0, 4'h8, 1'b0);
            `CHK(pc_o, 16'h0204)
            rdreg(4'h8, 16'h1234);
        end
    endtask
    // ----------------------------------------
    // Clock, timeout, main sequence
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial begin
        {reset_i, start_i, dst_mode_i, byte_i, reg_ld_i} = 5'b10000;
        {instr_addr_i, reg_ld_data_i, src_mode_i} = 34'h0;
        {src_reg_i, dst_reg_i, reg_ld_sel_i, rd_sel_i, wait_r} = 20'h0;
        repeat (20) @(posedge clk_sys_i);
        #1 reset_i = 1'b0;
        t_reg;
        t_byte;
        t_idx;
        t_sym;
        t_abs;
        t_bmem;
        tally_and_finish;
    end
endmodule
